/* rtl/ssp_clk_div.sv */
`timescale 1ns/1ps
module ssp_clk_div
	import ssp_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst,
	ssp_div_if.div    dv
);
	logic [DIV_W-1:0] cnt_r;
	logic [DIV_W-1:0] half;

	// Half serial period for the selected rate
	always_comb
	begin
		if (dv.rate == RATE_DIV4)
			half = HALF_DIV4;
		else if (dv.rate == RATE_DIV8)
			half = HALF_DIV8;
		else if (dv.rate == RATE_DIV16)
			half = HALF_DIV16;
		else
			half = HALF_DIV64;
	end

	assign dv.tick = dv.run && (cnt_r == half - DIV_W'(1));

	// Counter restarts whenever the master is idle
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			cnt_r <= DIV_RST;
		else if (!dv.run || dv.tick)
			cnt_r <= DIV_RST;
		else
			cnt_r <= cnt_r + DIV_W'(1);
	end
endmodule

/* rtl/ssp_sync2.sv */
`timescale 1ns/1ps
module ssp_sync2
	import ssp_pkg::*;
#(
	parameter int          WIDTH   = 4,
	parameter logic [WIDTH-1:0] RST_VAL = '0
)(
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinSync
);
	logic [WIDTH-1:0] meta_r;

	if (WIDTH < 1)
	begin : g_chk
		$error("ssp_sync2 width must be at least one");
	end

	// Two flops per pin; the first is read only by the second
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_r <= RST_VAL;
			pinSync <= RST_VAL;
		end
		else
		begin
			meta_r <= pinIn;
			pinSync <= meta_r;
		end
	end
endmodule

/* rtl/sync_serial_port.sv */
`timescale 1ns/1ps
//Contract
// - Master drives serial clock, slave receives it
// - Master emits eight clock pulses per transfer
// - Slave ignores clock while select is high
// - Master out on data-out, slave out on data-in
// - Slave data-out driven only when enabled
// - Shift on one edge, sample on other
// - Phase 0 edges per polarity
// - Phase 1 edges per polarity
// - Phase 0 first bit before first edge
// - Phase 1 data changes at first edge
// - Bit order selects MSB or LSB first
// - Done flag set after last shift
// - Phase 0 slave write with select low collides
// - Phase 1 slave write allowed when idle
// - Write during transfer counts as collision
// - Colliding write discarded, transfer continues
// - Collision detected in master and slave
// - Shift register replaced by received byte
// - Interrupt when done flag rises
// - Slave overflow when byte arrives unread
// - Overflow overwrites data register
// - Each pin selectable open-drain
// - Status read then data access clears flags
// - Master rate divides by 4/8/16/64
// - Mode fault raises interrupt when enabled
module sync_serial_port
	import ssp_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic [BYTE_W-1:0] wrData,
	input  wire logic              dataWr,
	input  wire logic              dataRd,
	input  wire logic              statusRd,
	input  wire logic              portEnable,
	input  wire logic              masterSelect,
	input  wire logic              clockPolarity,
	input  wire logic              clockPhase,
	input  wire logic              bitOrderLsb,
	input  wire logic [1:0]        rateSelect,
	input  wire logic              modeFaultOff,
	input  wire logic              odSclk,
	input  wire logic              odMosi,
	input  wire logic              odMiso,
	input  wire logic              sclkIn,
	output logic                   sclkOut,
	output logic                   sclkOe,
	input  wire logic              mosiIn,
	output logic                   mosiOut,
	output logic                   mosiOe,
	input  wire logic              misoIn,
	output logic                   misoOut,
	output logic                   misoOe,
	input  wire logic              selectN,
	output logic [BYTE_W-1:0]      shiftData,
	output logic                   transferDone,
	output logic                   writeCollision,
	output logic                   slaveOverflow,
	output logic                   modeFault,
	output logic                   busy,
	output logic                   serialIrq
);
	ssp_div_if   dvif ();
	ssp_state_t  state_r;
	logic [3:0]  pinS;
	logic        sclkS, mosiS, misoS, selNS;
	logic        sclkPrev_r, sclkLvl_r, dataOut_r, seen_r;
	logic [EDGE_W-1:0] edgeCnt_r, nEdge;
	logic [BYTE_W-1:0] shiftReg_r;
	logic        done_r, write_collision_flag_r, ovf_r, mf_r, irq_r;
	logic        mEdge, sEdge, edgeEv, isSample, isLaunch, byteDone;
	logic        slvActive, collide, accept, clearFlags, inBit, mfEvent;
	logic [2:0]  sIdx, lIdx, sIdxD_r;
	logic        sampD_r;

	function automatic logic [2:0] bitPos(input logic lsb,
		input logic [2:0] idx);
		bitPos = lsb ? idx : 3'h7 - idx;
	endfunction

	// Pins from outside pass two flops
	ssp_sync2 #(.WIDTH(4), .RST_VAL(4'h8)) u_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pinIn   ({selectN, misoIn, mosiIn, sclkIn}),
		.pinSync (pinS)
	);
	assign {selNS, misoS, mosiS, sclkS} = pinS;

	// Master serial clock divider
	assign dvif.run = (state_r == ST_XFER);
	assign dvif.rate = rateSelect;
	ssp_clk_div u_div (
		.sys_clk (sys_clk),
		.rst     (rst),
		.dv      (dvif.div)
	);

	// Edge events: master from divider, slave from sampled pin
	assign mEdge = masterSelect && dvif.tick;
	assign sEdge = !masterSelect && portEnable && !selNS
		&& (sclkS != sclkPrev_r);
	assign edgeEv = mEdge || sEdge;
	assign nEdge = edgeCnt_r + 5'h01;
	// Odd edges sample in phase 0, even edges in phase 1
	assign isSample = edgeEv && (nEdge[0] ^ clockPhase);
	assign isLaunch = edgeEv && !(nEdge[0] ^ clockPhase)
		&& (nEdge != EDGES_PER_BYTE);
	assign byteDone = edgeEv && (nEdge == EDGES_PER_BYTE);
	assign sIdx = bitPos(bitOrderLsb, edgeCnt_r[3:1]);
	assign lIdx = bitPos(bitOrderLsb,
		clockPhase ? edgeCnt_r[3:1] : nEdge[3:1]);
	assign inBit = masterSelect ? misoS : mosiS;

	// Write collision decode in both modes
	assign slvActive = (edgeCnt_r != EDGE_RST);
	assign collide = dataWr && (masterSelect ? (state_r == ST_XFER)
		: (clockPhase ? slvActive : !selNS));
	assign accept = dataWr && !collide;
	assign clearFlags = seen_r && (dataWr || dataRd);
	assign mfEvent = masterSelect && portEnable && !modeFaultOff
		&& !selNS;

	// Master sequencer
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			state_r <= ST_IDLE;
		else
		begin
			case (state_r)
				ST_IDLE:
					if (accept && masterSelect && portEnable)
						state_r <= ST_XFER;
				ST_XFER:
					if (byteDone || !masterSelect || !portEnable)
						state_r <= ST_IDLE;
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// Edge counter; slave select high aborts the byte
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			edgeCnt_r <= EDGE_RST;
		else if (byteDone)
			edgeCnt_r <= EDGE_RST;
		else if (masterSelect ? (state_r != ST_XFER) : selNS)
			edgeCnt_r <= EDGE_RST;
		else if (edgeEv)
			edgeCnt_r <= nEdge;
	end

	// Serial clock level and slave clock history
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sclkLvl_r <= 1'b0;
			sclkPrev_r <= 1'b0;
		end
		else
		begin
			sclkPrev_r <= sclkS;
			if (mEdge)
				sclkLvl_r <= !sclkLvl_r;
			else if (state_r != ST_XFER)
				sclkLvl_r <= clockPolarity;
		end
	end

	// Master samples a clock late: synced input lags the slave's launch
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sampD_r <= 1'b0;
			sIdxD_r <= 3'h0;
		end
		else
		begin
			sampD_r <= isSample && masterSelect;
			sIdxD_r <= sIdx;
		end
	end

	// Single shift register: load on write, fill in place
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			shiftReg_r <= SHIFT_RST;
		else if (accept)
			shiftReg_r <= wrData;
		else if (sampD_r)
			shiftReg_r[sIdxD_r] <= misoS;
		else if (isSample && !masterSelect)
			shiftReg_r[sIdx] <= inBit;
	end

	// Outgoing bit held stable between launch edges
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			dataOut_r <= 1'b0;
		else if (accept)
			dataOut_r <= wrData[bitPos(bitOrderLsb, 3'h0)];
		else if (isLaunch)
			dataOut_r <= shiftReg_r[lIdx];
		else if (byteDone && !clockPhase)
			dataOut_r <= shiftReg_r[bitPos(bitOrderLsb, 3'h0)];
	end

	// Status read arms the flag clear
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			seen_r <= 1'b0;
		else if (statusRd)
			seen_r <= 1'b1;
		else if (dataWr || dataRd)
			seen_r <= 1'b0;
	end

	// Sticky flags; a set wins over a clear
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			done_r <= 1'b0;
			write_collision_flag_r <= 1'b0;
			ovf_r <= 1'b0;
			mf_r <= 1'b0;
		end
		else
		begin
			done_r <= byteDone || (done_r && !clearFlags);
			write_collision_flag_r <= collide || (write_collision_flag_r && !clearFlags);
			ovf_r <= (!masterSelect && byteDone && done_r)
				|| (ovf_r && !clearFlags && !masterSelect);
			mf_r <= mfEvent || (mf_r && !clearFlags);
		end
	end

	// Interrupt pulse on done rising or mode fault
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			irq_r <= 1'b0;
		else
			irq_r <= (byteDone && !done_r)
				|| (mfEvent && !mf_r);
	end

	// Pins; open-drain drives low only
	always_comb
	begin
		sclkOut = odSclk ? 1'b0 : sclkLvl_r;
		sclkOe = masterSelect && portEnable
			&& (!odSclk || !sclkLvl_r);
		mosiOut = odMosi ? 1'b0 : dataOut_r;
		mosiOe = masterSelect && portEnable
			&& (!odMosi || !dataOut_r);
		misoOut = odMiso ? 1'b0 : dataOut_r;
		misoOe = !masterSelect && portEnable
			&& (!odMiso || !dataOut_r);
	end

	assign shiftData = shiftReg_r;
	assign transferDone = done_r;
	assign writeCollision = write_collision_flag_r;
	assign slaveOverflow = ovf_r;
	assign modeFault = mf_r;
	assign busy = (state_r == ST_XFER) || slvActive;
	assign serialIrq = irq_r;

	// Pulse counter for checking
	logic [3:0] pulseCnt_r;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			pulseCnt_r <= 4'h0;
		else if (state_r != ST_XFER)
			pulseCnt_r <= 4'h0;
		else if (mEdge && (sclkLvl_r == clockPolarity))
			pulseCnt_r <= pulseCnt_r + 4'h1;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_eight_pulses: assert property (
		(state_r == ST_XFER) && byteDone |-> pulseCnt_r == 4'h8)
		else $error("master byte without eight clock pulses");
	a_idle_level: assert property (
		(state_r == ST_IDLE) && $past(state_r == ST_IDLE)
		|-> sclkLvl_r == $past(clockPolarity))
		else $error("serial clock not at idle level");
	a_first_edge: assert property (
		$rose(state_r == ST_XFER) && rateSelect == RATE_DIV4
		&& $stable(rateSelect)
		|-> (sclkLvl_r == clockPolarity)[*2]
		##1 sclkLvl_r != clockPolarity)
		else $error("first edge not half a period after start");
	a_select_high: assert property (
		!masterSelect && selNS |=> edgeCnt_r == EDGE_RST)
		else $error("slave counted edges while deselected");
	a_miso_release: assert property (
		!portEnable |-> !misoOe && !mosiOe && !sclkOe)
		else $error("pin driven while port disabled");
	a_write_collide: assert property (
		dataWr && (state_r == ST_XFER) |=> writeCollision
		&& (state_r == ST_XFER || $past(byteDone)))
		else $error("master write in transfer not flagged");
	a_slave_ph0: assert property (
		dataWr && !masterSelect && !clockPhase && !selNS
		|=> writeCollision && shiftData != $past(wrData)
		|| $past(shiftReg_r) == $past(wrData) || $past(isSample))
		else $error("phase 0 slave write with select low loaded");
	a_done_irq: assert property (
		$rose(transferDone) |-> serialIrq)
		else $error("no interrupt on done rising");
	a_ovf_master: assert property (
		masterSelect |=> !slaveOverflow)
		else $error("overflow flag kept in master mode");
endmodule

/* shared/ssp_div_if.sv */
`timescale 1ns/1ps
// Master clock divider hookup
interface ssp_div_if;
	logic       run;
	logic [1:0] rate;
	logic       tick;
	modport ctl (output run, output rate, input tick);
	modport div (input run, input rate, output tick);
endinterface

/* shared/ssp_pkg.sv */
package ssp_pkg;
	localparam int BYTE_W = 8;
	localparam int EDGE_W = 5;
	localparam int DIV_W = 6;
	// Serial clock edges in one byte: two per bit
	localparam logic [EDGE_W-1:0] EDGES_PER_BYTE = 5'h10;
	// Half serial period in system clocks for rate codes 00..11
	localparam logic [DIV_W-1:0] HALF_DIV4 = 6'h02;
	localparam logic [DIV_W-1:0] HALF_DIV8 = 6'h04;
	localparam logic [DIV_W-1:0] HALF_DIV16 = 6'h08;
	localparam logic [DIV_W-1:0] HALF_DIV64 = 6'h20;
	localparam logic [1:0] RATE_DIV4 = 2'h0;
	localparam logic [1:0] RATE_DIV8 = 2'h1;
	localparam logic [1:0] RATE_DIV16 = 2'h2;
	// Values after reset
	localparam logic [BYTE_W-1:0] SHIFT_RST = 8'h00;
	localparam logic [EDGE_W-1:0] EDGE_RST = 5'h00;
	localparam logic [DIV_W-1:0] DIV_RST = 6'h00;
	// Master sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_XFER = 2'b10
	} ssp_state_t;
endpackage

/* tb/ssp_ext_slave.sv */
`timescale 1ns/1ps
// Behavioural slave on the far side of a master transfer
module ssp_ext_slave
(
	input  wire logic       sclk,
	input  wire logic       mosi,
	input  wire logic       clock_polarity_bit,
	input  wire logic       clock_phase_bit,
	input  wire logic       lsbFirst,
	input  wire logic       load,
	input  wire logic [7:0] txByte,
	output logic            miso,
	output logic [7:0]      rxByte,
	output int              edgeCount
);
	int bitIdx;

	function automatic int pos(input int k);
		return lsbFirst ? k : 7 - k;
	endfunction

	// Arm a byte; phase 0 shows its first bit before the first edge
	always @(posedge load)
	begin
		bitIdx = 0;
		edgeCount = 0;
		miso = clock_phase_bit ? ~miso : txByte[pos(0)];
	end

	// Sample on one edge, shift on the other; stale bit inverted at end
	always @(sclk)
	begin
		edgeCount = edgeCount + 1;
		if (sclk === (clock_polarity_bit ~^ clock_phase_bit))
		begin
			if (bitIdx < 8)
				rxByte[pos(bitIdx)] = mosi;
			bitIdx = bitIdx + 1;
		end
		else
			miso = (bitIdx < 8) ? txByte[pos(bitIdx)] : ~miso;
	end

	initial
	begin
		miso = 1'b0;
		rxByte = 8'h00;
		edgeCount = 0;
		bitIdx = 0;
	end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench
	import ssp_pkg::*;
;
	logic       sys_clk, rst, dataWr, dataRd, statusRd, portEnable;
	logic       masterSelect, clockPolarity, clockPhase, bitOrderLsb;
	logic       selectN, load;
	logic [1:0] rateSelect;
	logic [7:0] wrData, txByte, rxByte, shiftData;
	logic       sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe;
	logic       transferDone, writeCollision, serialIrq, pMiso, busy, ovf;
	wire        sclkIn, mosiIn, misoIn;
	int         badCount, checksDone, irqCount, edgeCount, n, expIrq;
	int         halfTbl[4] = '{2, 4, 8, 32};

	// Wire levels with pull-ups where nobody drives
	assign sclkIn = sclkOe ? sclkOut : 1'b1;
	assign mosiIn = mosiOe ? mosiOut : 1'b1;
	assign misoIn = misoOe ? misoOut : pMiso;

	sync_serial_port dut_u (.sys_clk, .rst, .wrData, .dataWr, .dataRd,
		.statusRd, .portEnable, .masterSelect, .clockPolarity, .clockPhase,
		.bitOrderLsb, .rateSelect, .modeFaultOff(1'b1), .odSclk(1'b0),
		.odMosi(1'b0), .odMiso(1'b0), .sclkIn, .sclkOut, .sclkOe, .mosiIn,
		.mosiOut, .mosiOe, .misoIn, .misoOut, .misoOe, .selectN, .shiftData,
		.transferDone, .writeCollision, .slaveOverflow(ovf), .modeFault(),
		.busy, .serialIrq);

	ssp_ext_slave slave_u (.sclk(sclkIn), .mosi(mosiIn), .clock_polarity_bit(clockPolarity),
		.clock_phase_bit(clockPhase), .lsbFirst(bitOrderLsb), .load, .txByte,
		.miso(pMiso), .rxByte, .edgeCount);

	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// Interrupt pulses seen
	always @(posedge sys_clk)
		if (serialIrq === 1'b1)
			irqCount++;

	task automatic step;
		@(posedge sys_clk);
		#1;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checksDone++;
		if (got !== exp)
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		if (got !== exp)
			badCount++;
	endtask

	task automatic write(input logic [7:0] d);
		wrData = d;
		dataWr = 1'b1;
		step;
		dataWr = 1'b0;
	endtask

	// Status read arms, data read clears
	task automatic clear_flags;
		statusRd = 1'b1;
		step;
		statusRd = 1'b0;
		dataRd = 1'b1;
		step;
		dataRd = 1'b0;
	endtask

	task automatic stop_test;
		if (badCount == 0 && checksDone > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Main sequence: four formats as master, then slave checks
	initial
	begin
		{rst, dataWr, dataRd, statusRd, load} = 5'h10;
		{portEnable, masterSelect, clockPolarity, clockPhase} = 4'h0;
		{bitOrderLsb, rateSelect, selectN, wrData, txByte} = 20'h10000;
		{badCount, checksDone, irqCount} = 0;
		repeat (8) @(posedge sys_clk);
		#1 rst = 1'b0;
		step;
		masterSelect = 1'b1;
		portEnable = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			clockPolarity = i[0];
			clockPhase = i[1];
			bitOrderLsb = i[0] ^ i[1];
			rateSelect = i[1:0];
			txByte = 8'h3C + 8'(i);
			step;
			step;
			check(sclkIn, clockPolarity);
			load = 1'b1;
			step;
			load = 1'b0;
			expIrq = irqCount + 1;
			write(8'hA5 ^ 8'(i));
			repeat (3) step;
			write(8'h0F);
			check(busy, 8'h01);
			n = 0;
			while (transferDone !== 1'b1 && n < 3000)
			begin
				step;
				n++;
			end
			n = n + 4;
			step;
			check(8'(n >= 16 * halfTbl[i] && n <= 16 * halfTbl[i] + 2), 8'h01);
			check(8'(edgeCount), 8'h10);
			check(rxByte, 8'hA5 ^ 8'(i));
			check(shiftData, txByte);
			check(writeCollision, 1'b1);
			check(8'(irqCount), 8'(expIrq));
			check(ovf, 8'h00);
			clear_flags;
			check({transferDone, writeCollision}, 2'h0);
		end
		masterSelect = 1'b0;
		portEnable = 1'b0;
		clockPhase = 1'b0;
		step;
		check({sclkOe, misoOe}, 2'h0);
		portEnable = 1'b1;
		step;
		check({misoOe, mosiOe}, 2'h2);
		selectN = 1'b0;
		repeat (3) step;
		write(8'h5A);
		step;
		check(writeCollision, 1'b1);
		selectN = 1'b1;
		clear_flags;
		clockPhase = 1'b1;
		selectN = 1'b0;
		repeat (3) step;
		write(8'h69);
		step;
		check(writeCollision, 1'b0);
		check(shiftData, 8'h69);
		stop_test;
	end

	// Watchdog well beyond the expected run length
	initial
	begin
		#100000;
		badCount++;
		stop_test;
	end
endmodule
